// ===== include/host_glue_defs.svh
/*
  Op-code, vectors, priorities and bus width for the host bus glue.
  Assumes inclusion by bare name from the glue package and module.
*/
`ifndef HOST_GLUE_DEFS_SVH
`define HOST_GLUE_DEFS_SVH

// Restart op-code that sends the vectored host to 0020.
`define RESTART_OPCODE 8'he7
`define VECTORED_ISR_ADDR 16'h0020
// Fixed service addresses of the direct inputs.
`define EDGE_ISR_ADDR 16'h003c
`define LEVEL_HI_ISR_ADDR 16'h0034
`define LEVEL_LO_ISR_ADDR 16'h002c
// Microcontroller interrupt vector locations.
`define MCU_VECTOR_HI_ADDR 16'hfff2
`define MCU_VECTOR_LO_ADDR 16'hfff3
// Priority levels of the four maskable inputs.
`define PRIO_EDGE 3'h2
`define PRIO_LEVEL_HI 3'h3
`define PRIO_LEVEL_LO 3'h4
`define PRIO_VECTORED 3'h5
// Width of the shared address/data bus.
`define ADDR_BYTE_WIDTH 8

`endif

// ===== include/host_glue_pkg.sv
/*
  Types shared by the host bus glue.
  Assumes the defs header is on the include path.
*/
`include "host_glue_defs.svh"

package host_glue_pkg;

  // Which host input carries the peripheral request.
  typedef enum logic [1:0] {
    ROUTE_EDGE,
    ROUTE_LEVEL_HI,
    ROUTE_LEVEL_LO,
    ROUTE_VECTORED
  } irq_route_type;

  // Strobes toward the peripheral.
  typedef struct packed {
    logic read_n;
    logic write_n;
  } strobe_type;

  // Host interrupt inputs, active high except the microcontroller one.
  typedef struct packed {
    logic edge_req;
    logic level_hi_req;
    logic level_lo_req;
    logic vectored_irq_request;
    logic mcu_irq_n;
  } irq_lines_type;

endpackage

// ===== verilog/host_irq_bus_glue.sv
/*
  Host side glue between a dual UART and a multiplexed-bus host: address
  latch, strobe mapping, interrupt routing, vector buffer and mode straps.
  Assumes bus, mode-select and UART pins arrive asynchronously and are synchronised here; the configuration straps are not.
*/
`include "host_glue_defs.svh"

module host_irq_bus_glue
  import host_glue_pkg::*;
#(
  parameter int ADDR_WIDTH = `ADDR_BYTE_WIDTH
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_i,
  // Host bus pins.
  input wire logic [ADDR_WIDTH-1:0] shared_addr_data_i,
  input wire logic [ADDR_WIDTH-1:0] upper_addr_i,
  input wire logic addr_latch_strobe_i,
  input wire logic mem_read_n_i,
  input wire logic mem_write_n_i,
  input wire logic io_read_n_i,
  input wire logic io_write_n_i,
  input wire logic irq_acknowledge_n_i,
  input wire logic mode_select_a_i,
  input wire logic mode_select_b_i,
  // Configuration straps.
  input wire logic use_io_strobes_i,
  input wire irq_route_type route_i,
  // Peripheral pins.
  input wire logic uart_irq_n_i,
  // Demultiplexed address and strobes.
  output logic [2*ADDR_WIDTH-1:0] address_o,
  output strobe_type strobe_o,
  // Host interrupt lines and vector drive.
  output irq_lines_type irq_o,
  output logic [ADDR_WIDTH-1:0] shared_addr_data_o,
  output logic shared_addr_data_oe_o,
  // Status.
  output logic expanded_mode_o
);

  typedef enum logic [1:0] {
    RESET_HOLD,
    RUN
  } mode_state_type;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_BITS = 2 * ADDR_WIDTH + 9;
  logic [SYNC_BITS-1:0] raw;
  logic [SYNC_BITS-1:0] sync_a;
  logic [SYNC_BITS-1:0] sync_b;
  logic [ADDR_WIDTH-1:0] bus_s;
  logic [ADDR_WIDTH-1:0] upper_s;
  logic as_s;
  logic mem_read_n_s;
  logic mem_write_n_s;
  logic ior_s;
  logic iow_s;
  logic ack_n_s;
  logic mode_select_a_s;
  logic mode_select_b_s;
  logic irq_n_s;

  // Gather every bus, mode-select and UART pin so one pair of flip-flops covers them all.
  always_comb begin
    raw = {shared_addr_data_i, upper_addr_i, addr_latch_strobe_i, mem_read_n_i,
           mem_write_n_i, io_read_n_i, io_write_n_i, irq_acknowledge_n_i,
           mode_select_a_i, mode_select_b_i, uart_irq_n_i};
  end

  // Two stages; only the second stage is read by logic. They are not reset,
  // so the straps seen at release are the levels held during reset, and no
  // false address strobe or request follows reset.
  always_ff @(posedge clock_i) begin
    sync_a <= raw;
    sync_b <= sync_a;
  end

  // Split the synchronised vector back into named pins.
  always_comb begin
    {bus_s, upper_s, as_s, mem_read_n_s, mem_write_n_s, ior_s, iow_s, ack_n_s, mode_select_a_s, mode_select_b_s,
     irq_n_s} = sync_b;
  end

  // ----------------------------------------------------------------
  // Address demultiplexing
  // ----------------------------------------------------------------
  logic [ADDR_WIDTH-1:0] low_addr;
  logic [ADDR_WIDTH-1:0] next_low_addr;
  logic [ADDR_WIDTH-1:0] high_addr;
  logic [ADDR_WIDTH-1:0] next_high_addr;

  // While the strobe is high the shared bus holds the low address byte.
  always_comb begin
    next_low_addr = low_addr;
    next_high_addr = high_addr;
    if (as_s) begin
      next_low_addr = bus_s;
      next_high_addr = expanded_mode_o ? upper_s : '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      low_addr <= '0;
      high_addr <= '0;
    end else begin
      low_addr <= next_low_addr;
      high_addr <= next_high_addr;
    end
  end

  assign address_o = {high_addr, low_addr};

  // ----------------------------------------------------------------
  // Strobe mapping
  // ----------------------------------------------------------------
  strobe_type next_strobe;

  // Memory strobes by default, I/O strobes when the strap asks.
  always_comb begin
    next_strobe.read_n = use_io_strobes_i ? ior_s : mem_read_n_s;
    next_strobe.write_n = use_io_strobes_i ? iow_s : mem_write_n_s;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      strobe_o <= '{read_n: 1'b1, write_n: 1'b1};
    end else begin
      strobe_o <= next_strobe;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt routing and vector buffer
  // ----------------------------------------------------------------
  irq_lines_type next_irq;
  logic req;
  logic next_oe;

  // The request stays up until firmware clears the cause in the UART.
  assign req = ~irq_n_s;

  // The selected host input and the microcontroller line both carry the request; the edge input sees
  // the rising edge of this level. No acknowledge is generated for direct routes.
  always_comb begin
    next_irq = '0;
    next_irq.mcu_irq_n = irq_n_s;
    case (route_i)
      ROUTE_EDGE: next_irq.edge_req = req;
      ROUTE_LEVEL_HI: next_irq.level_hi_req = req;
      ROUTE_LEVEL_LO: next_irq.level_lo_req = req;
      ROUTE_VECTORED: next_irq.vectored_irq_request = req;
      default: next_irq = '0;
    endcase
    next_irq.mcu_irq_n = irq_n_s;
  end

  // Drive the restart op-code only while request and acknowledge are low.
  always_comb begin
    next_oe = (route_i == ROUTE_VECTORED) && !irq_n_s && !ack_n_s;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      irq_o <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      shared_addr_data_oe_o <= 1'b0;
      shared_addr_data_o <= '0;
    end else begin
      irq_o <= next_irq;
      shared_addr_data_oe_o <= next_oe;
      shared_addr_data_o <= ADDR_WIDTH'(`RESTART_OPCODE);
    end
  end

  // ----------------------------------------------------------------
  // Mode straps
  // ----------------------------------------------------------------
  mode_state_type state;
  mode_state_type next_state;
  logic next_expanded;

  // Straps are caught at the first clock after reset is released.
  always_comb begin
    next_state = state;
    next_expanded = expanded_mode_o;
    case (state)
      RESET_HOLD: begin
        next_expanded = mode_select_a_s && mode_select_b_s;
        next_state = RUN;
      end
      RUN: next_state = RUN;
      default: next_state = RESET_HOLD;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state <= RESET_HOLD;
      expanded_mode_o <= 1'b0;
    end else begin
      state <= next_state;
      expanded_mode_o <= next_expanded;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_vector_enable: assert property (@(posedge clock_i) disable iff (reset_i)
    shared_addr_data_oe_o |-> $past(!irq_n_s && !ack_n_s))
    else $error("vector buffer enabled without request and acknowledge");
  chk_vector_value: assert property (@(posedge clock_i) disable iff (reset_i)
    shared_addr_data_oe_o |-> shared_addr_data_o == ADDR_WIDTH'(`RESTART_OPCODE))
    else $error("wrong restart op-code driven");
  chk_irq_invert: assert property (@(posedge clock_i) disable iff (reset_i)
    (route_i == ROUTE_LEVEL_HI) ##1 (route_i == ROUTE_LEVEL_HI) |->
      irq_o.level_hi_req == $past(req))
    else $error("level request not inverted peripheral request");
  chk_mcu_line: assert property (@(posedge clock_i) disable iff (reset_i)
    ##1 irq_o.mcu_irq_n == $past(irq_n_s))
    else $error("microcontroller request does not follow peripheral");
  chk_addr_latch: assert property (@(posedge clock_i) disable iff (reset_i)
    as_s |=> low_addr == $past(bus_s))
    else $error("low address not latched under strobe");
  chk_addr_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    !as_s |=> $stable(low_addr))
    else $error("low address changed in data phase");
  chk_strobe_map: assert property (@(posedge clock_i) disable iff (reset_i)
    !use_io_strobes_i |=> strobe_o.read_n == $past(mem_read_n_s) || $changed(use_io_strobes_i))
    else $error("memory read strobe not mapped");
  chk_mode_steady: assert property (@(posedge clock_i) disable iff (reset_i)
    state == RUN |=> $stable(expanded_mode_o))
    else $error("mode changed outside reset");

  cov_vectored: cover property (@(posedge clock_i) disable iff (reset_i)
    shared_addr_data_oe_o);
  cov_edge: cover property (@(posedge clock_i) disable iff (reset_i)
    $rose(irq_o.edge_req));
  cov_expanded: cover property (@(posedge clock_i) disable iff (reset_i)
    expanded_mode_o);

endmodule

// ===== dv/uart_model.sv
/*
  Behavioural model of the dual UART as the glue sees it: request pin and strobes.
  Assumes the bench pulses raise_i for one clock, changed just after a rising edge.
*/
module uart_model
  import host_glue_pkg::*;
(
  // Clock.
  input wire logic clock_i,
  // Strobes from the glue and commands from the bench.
  input wire strobe_type strobe_i,
  input wire logic raise_i,
  input wire logic [2:0] delay_i,
  // Active low request pin.
  output logic irq_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_count = 4'h0;
  initial irq_n_o = 1'b1;
  // A write clears the cause; a raise drops the request after a chosen delay.
  always @(posedge clock_i) begin
    if (strobe_i.write_n === 1'b0) begin
      irq_n_o <= 1'b1;
      wait_count <= 4'h0;
    end else if (raise_i) begin
      wait_count <= {1'b0, delay_i} + 4'h1;
    end else if (wait_count != 4'h0) begin
      wait_count <= wait_count - 4'h1;
      if (wait_count == 4'h1) irq_n_o <= 1'b0;
    end
  end
endmodule

// ===== dv/testbench.sv
/*
  Self-checking bench for the host bus glue with a UART model on the far side.
  Assumes outputs settle within twelve clocks of any stimulus change.
*/
module testbench
  import host_glue_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus, outputs and score keeping
  // ----------------------------------------
  logic clock_i = 1'b0, reset_i = 1'b1, las = 1'b0, raise = 1'b0;
  logic mem_rd_n = 1'b1, mem_wr_n = 1'b1, io_rd_n = 1'b1, io_wr_n = 1'b1, ack_n = 1'b1;
  logic ma = 1'b0, mb = 1'b0, use_io = 1'b0, mode = 1'b0, uart_irq_n, oe, expanded;
  logic [7:0] bus = 8'h00, upper = 8'h00, lo = 8'h00, hi = 8'h00, vec;
  logic [2:0] dly = 3'h0;
  logic pending = 1'b0;
  irq_route_type route = ROUTE_EDGE;
  logic [15:0] address;
  strobe_type strobe;
  irq_lines_type irq;
  logic [32:0] notes[$];
  int n_fail = 0, n_checks = 0;
  event ev;

  host_irq_bus_glue DUT (.clock_i(clock_i), .reset_i(reset_i), .shared_addr_data_i(bus),
    .upper_addr_i(upper), .addr_latch_strobe_i(las), .mem_read_n_i(mem_rd_n),
    .mem_write_n_i(mem_wr_n), .io_read_n_i(io_rd_n), .io_write_n_i(io_wr_n),
    .irq_acknowledge_n_i(ack_n), .mode_select_a_i(ma), .mode_select_b_i(mb),
    .use_io_strobes_i(use_io), .route_i(route), .uart_irq_n_i(uart_irq_n),
    .address_o(address), .strobe_o(strobe), .irq_o(irq), .shared_addr_data_o(vec),
    .shared_addr_data_oe_o(oe), .expanded_mode_o(expanded));
  uart_model partner (.clock_i(clock_i), .strobe_i(strobe), .raise_i(raise),
    .delay_i(dly), .irq_n_o(uart_irq_n));

  // 40 MHz clock.
  initial forever #12.5 clock_i = ~clock_i;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Waits for edges, then steps just past the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask

  // Lets outputs settle and notes what every output should show.
  task automatic settle();
    logic [32:0] e;
    logic r;
    tick(12);
    r = pending;
    e[32:17] = {mode ? hi : 8'h00, lo};
    e[16:15] = use_io ? {io_rd_n, io_wr_n} : {mem_rd_n, mem_wr_n};
    e[14:10] = {route == ROUTE_EDGE && r, route == ROUTE_LEVEL_HI && r,
      route == ROUTE_LEVEL_LO && r, route == ROUTE_VECTORED && r, !r};
    e[9] = route == ROUTE_VECTORED && r && !ack_n;
    e[8:1] = e[9] ? 8'he7 : 8'h00;
    e[0] = mode;
    notes.push_back(e);
    ->ev;
  endtask

  // Holds reset for ten clocks with the given mode straps.
  task automatic do_reset(input logic a, input logic b);
    ma = a;
    mb = b;
    reset_i = 1'b1;
    lo = 8'h00;
    hi = 8'h00;
    mode = a & b;
    tick(10);
    reset_i = 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Monitor, watchdog and tests
  // ----------------------------------------
  // Compares the oldest note with the outputs; vector data counts only while driven.
  initial forever begin
    @(ev);
    n_checks++;
    if ({address, strobe, irq, oe, vec & {8{oe}}, expanded} !== notes[0]) begin
      n_fail++;
      $display("CHECK FAILED outputs expected %h seen %h", notes[0],
        {address, strobe, irq, oe, vec & {8{oe}}, expanded});
    end
    void'(notes.pop_front());
  end

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #50000;
    n_fail++;
    conclude();
  end

  // Mode straps, address latch, strobe mapping, then every interrupt route.
  initial begin
    void'($urandom(4024));
    do_reset(1'b1, 1'b0);
    settle();
    // Two addresses with the upper port unused, then two in expanded mode.
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        do_reset(1'b1, 1'b1);
        settle();
      end
      lo = 8'($urandom);
      hi = 8'($urandom);
      bus = lo;
      upper = hi;
      las = 1'b1;
      tick(4);
      las = 1'b0;
      tick(1);
      bus = ~lo;
      upper = ~hi;
      settle();
    end
    for (int i = 0; i < 8; i++) begin
      use_io = i[2];
      {mem_rd_n, mem_wr_n, io_rd_n, io_wr_n} = 4'($urandom);
      settle();
    end
    {mem_rd_n, mem_wr_n, io_rd_n, io_wr_n} = 4'hf;
    use_io = 1'b0;
    // Let the idle strobes reach the model so a late write cannot eat a raise.
    tick(4);
    for (int r = 0; r < 4; r++) begin
      route = irq_route_type'(r);
      dly = 3'($urandom);
      raise = 1'b1;
      pending = 1'b1;
      tick(1);
      raise = 1'b0;
      settle();
      ack_n = 1'b0;
      settle();
      ack_n = 1'b1;
      settle();
      mem_wr_n = 1'b0;
      pending = 1'b0;
      settle();
      mem_wr_n = 1'b1;
      ack_n = 1'b0;
      settle();
      ack_n = 1'b1;
    end
    tick(1);
    conclude();
  end
endmodule
